// ==== core/timer_toggle_top.sv ====
// Timer block top: register file, toggle output, demodulation edge logic
`timescale 1ns/1ps
`include "timer_cfg.svh"
module timer_toggle_top
(
    input  wire logic                CLK_SYS_I,
    input  wire logic                RST_N_I,
    input  wire timer_pkg::reg_addr_t REG_ADDR_I,
    input  wire logic                REG_WR_I,
    input  wire timer_pkg::byte_t    REG_WDATA_I,
    input  wire logic                PORT_DATA_BIT_I,
    input  wire logic                PORT_FIVE_DIR_BIT_I,
    input  wire logic                DEMOD_INPUT_I,
    output timer_pkg::byte_t         REG_RDATA_O,
    output logic                     TOGGLE_OUTPUT_PIN_O,
    output logic                     TOGGLE_OUTPUT_PIN_OE_N_O,
    output logic                     COUNTER_END_IRQ_O,
    output logic                     CAPTURE_IRQ_O,
    output logic                     TIMEOUT_IRQ_O
);
    import timer_pkg::*;

    timer_link_if lnk ();

    byte_t tmr_reg, tmr_next;
    byte_t pre_reg, pre_next;
    byte_t start_reg, start_next;
    byte_t dctl_reg, dctl_next;
    byte_t dedge_reg, dedge_next;
    byte_t drlh_reg, drlh_next;
    byte_t drll_reg, drll_next;
    byte_t caph_reg, caph_next;
    byte_t capl_reg, capl_next;
    byte_t rdata_reg, rdata_next;
    logic  phase_clr_reg, phase_clr_next;
    logic  toggle_output_reg, toggle_output_next;
    logic  pin_reg, pin_next;
    logic  oe_n_reg, oe_n_next;
    logic  eoc_irq_reg, eoc_irq_next;
    logic  cap_irq_reg, cap_irq_next;
    logic  to_irq_reg, to_irq_next;
    logic  sync1_reg, sync2_reg, prev_reg;
    logic  rise_reg, rise_next;
    logic  fall_reg, fall_next;
    logic  wr_tmr, wr_dctl, wr_dedge;

    function automatic logic hit(input reg_addr_t a, input reg_addr_t target);
        hit = (a == target);
    endfunction

    // Register file and general timer control
    always_comb
    begin
        wr_tmr         = REG_WR_I & hit(REG_ADDR_I, `TMR_ADDR);
        wr_dctl        = REG_WR_I & hit(REG_ADDR_I, `DCTL_ADDR);
        wr_dedge       = REG_WR_I & hit(REG_ADDR_I, `DEDGE_ADDR);
        tmr_next       = tmr_reg;
        pre_next       = pre_reg;
        start_next     = start_reg;
        drlh_next      = drlh_reg;
        drll_next      = drll_reg;
        phase_clr_next = 1'b0;
        tmr_next[`TMR_LOAD_BIT] = 1'b0;
        // Single pass ends by dropping count-enable
        if (lnk.gt_eoc && !pre_reg[`PRE_CONT_BIT])
        begin
            tmr_next[`TMR_EN_BIT] = 1'b0;
        end
        if (wr_tmr)
        begin
            tmr_next = REG_WDATA_I;
            // Enabling from rest restarts the tick phase
            phase_clr_next = REG_WDATA_I[`TMR_EN_BIT] & ~tmr_reg[`TMR_EN_BIT];
        end
        if (REG_WR_I && hit(REG_ADDR_I, `PRE_ADDR))
        begin
            pre_next = REG_WDATA_I;
        end
        if (REG_WR_I && hit(REG_ADDR_I, `START_ADDR))
        begin
            start_next = REG_WDATA_I;
        end
        if (REG_WR_I && hit(REG_ADDR_I, `DRLH_ADDR))
        begin
            drlh_next = REG_WDATA_I;
        end
        if (REG_WR_I && hit(REG_ADDR_I, `DRLL_ADDR))
        begin
            drll_next = REG_WDATA_I;
        end
    end

    // Toggle output and pin
    always_comb
    begin
        toggle_output_next    = toggle_output_reg;
        eoc_irq_next = lnk.gt_eoc;
        if (wr_tmr && REG_WDATA_I[`TMR_LOAD_BIT])
        begin
            toggle_output_next = 1'b1;
        end
        else if (lnk.gt_eoc && tmr_reg[`TMR_SEL_HI:`TMR_SEL_LO] == `SEL_GENERAL)
        begin
            // Equal halves in continuous mode give the even duty cycle
            toggle_output_next = ~toggle_output_reg;
        end
        if (tmr_reg[`TMR_SEL_HI:`TMR_SEL_LO] == `SEL_OFF)
        begin
            pin_next = PORT_DATA_BIT_I;
        end
        else
        begin
            pin_next = toggle_output_next;
        end
        // Direction bit set means input, so the pin is released
        oe_n_next = PORT_FIVE_DIR_BIT_I;
    end

    // Demodulation edges, status flags and captures
    always_comb
    begin
        rise_next    = sync2_reg & ~prev_reg & dedge_reg[`DEDGE_SEL_LO];
        fall_next    = ~sync2_reg & prev_reg & dedge_reg[`DEDGE_SEL_HI];
        dctl_next    = dctl_reg;
        dedge_next   = dedge_reg;
        caph_next    = caph_reg;
        capl_next    = capl_reg;
        cap_irq_next = (lnk.dm_cap_rise | lnk.dm_cap_fall) & dctl_reg[`DCTL_CAPIE_BIT];
        to_irq_next  = lnk.dm_timeout & dctl_reg[`DCTL_TOIE_BIT];
        if (wr_dctl)
        begin
            dctl_next = {REG_WDATA_I[7:6], dctl_reg[`DCTL_TO_BIT] & ~REG_WDATA_I[`DCTL_TO_BIT],
                         REG_WDATA_I[4:0]};
        end
        if (wr_dedge)
        begin
            dedge_next = {REG_WDATA_I[7:2], dedge_reg[1:0] & ~REG_WDATA_I[1:0]};
        end
        // Hardware set wins over a software clear in the same cycle
        if (lnk.dm_timeout)
        begin
            dctl_next[`DCTL_TO_BIT] = 1'b1;
        end
        if (lnk.dm_cap_rise)
        begin
            capl_next = lnk.dm_cap_value;
            dedge_next[`DEDGE_RISE_ST] = 1'b1;
        end
        if (lnk.dm_cap_fall)
        begin
            caph_next = lnk.dm_cap_value;
            dedge_next[`DEDGE_FALL_ST] = 1'b1;
        end
    end

    // Read data, registered one cycle after the address
    always_comb
    begin
        unique case (REG_ADDR_I)
            `TMR_ADDR:   rdata_next = tmr_reg;
            `PRE_ADDR:   rdata_next = pre_reg;
            `START_ADDR: rdata_next = start_reg;
            `DCTL_ADDR:  rdata_next = dctl_reg;
            `DEDGE_ADDR: rdata_next = dedge_reg;
            `DRLH_ADDR:  rdata_next = drlh_reg;
            `DRLL_ADDR:  rdata_next = drll_reg;
            `DCAPH_ADDR: rdata_next = caph_reg;
            `DCAPL_ADDR: rdata_next = capl_reg;
            default:     rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            tmr_reg       <= `REG_RST;
            pre_reg       <= `REG_RST;
            start_reg     <= `REG_RST;
            dctl_reg      <= `REG_RST;
            dedge_reg     <= `REG_RST;
            drlh_reg      <= `REG_RST;
            drll_reg      <= `REG_RST;
            caph_reg      <= `REG_RST;
            capl_reg      <= `REG_RST;
            rdata_reg     <= `REG_RST;
            phase_clr_reg <= 1'b0;
            toggle_output_reg      <= 1'b1;
            pin_reg       <= 1'b0;
            oe_n_reg      <= 1'b1;
            eoc_irq_reg   <= 1'b0;
            cap_irq_reg   <= 1'b0;
            to_irq_reg    <= 1'b0;
            sync1_reg     <= 1'b0;
            sync2_reg     <= 1'b0;
            prev_reg      <= 1'b0;
            rise_reg      <= 1'b0;
            fall_reg      <= 1'b0;
        end
        else
        begin
            tmr_reg       <= tmr_next;
            pre_reg       <= pre_next;
            start_reg     <= start_next;
            dctl_reg      <= dctl_next;
            dedge_reg     <= dedge_next;
            drlh_reg      <= drlh_next;
            drll_reg      <= drll_next;
            caph_reg      <= caph_next;
            capl_reg      <= capl_next;
            rdata_reg     <= rdata_next;
            phase_clr_reg <= phase_clr_next;
            toggle_output_reg      <= toggle_output_next;
            pin_reg       <= pin_next;
            oe_n_reg      <= oe_n_next;
            eoc_irq_reg   <= eoc_irq_next;
            cap_irq_reg   <= cap_irq_next;
            to_irq_reg    <= to_irq_next;
            sync1_reg     <= DEMOD_INPUT_I;
            sync2_reg     <= sync1_reg;
            prev_reg      <= sync2_reg;
            rise_reg      <= rise_next;
            fall_reg      <= fall_next;
        end
    end

    // The stored load bit is itself the one-cycle load pulse
    assign lnk.gt_restart     = tmr_reg[`TMR_LOAD_BIT];
    assign lnk.gt_phase_clr   = phase_clr_reg;
    assign lnk.gt_enable      = tmr_reg[`TMR_EN_BIT];
    assign lnk.gt_continuous  = pre_reg[`PRE_CONT_BIT];
    assign lnk.gt_pre_value   = pre_reg[`PRE_VAL_HI:`PRE_VAL_LO];
    assign lnk.gt_start_value = start_reg;
    assign lnk.dm_enable      = dctl_reg[`DCTL_EN_BIT];
    assign lnk.dm_clk_sel     = dctl_reg[`DCTL_CLK_HI:`DCTL_CLK_LO];
    assign lnk.dm_rise        = rise_reg;
    assign lnk.dm_fall        = fall_reg;
    assign lnk.dm_reload      = drlh_reg;

    general_down_counter #(
        .TICK_DIV (`GT_TICK_DIV)
    ) u_general (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RST_N_I),
        .lnk     (lnk)
    );

    demod_down_counter u_demod (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RST_N_I),
        .lnk     (lnk)
    );

    assign REG_RDATA_O              = rdata_reg;
    assign TOGGLE_OUTPUT_PIN_O      = pin_reg;
    assign TOGGLE_OUTPUT_PIN_OE_N_O = oe_n_reg;
    assign COUNTER_END_IRQ_O        = eoc_irq_reg;
    assign CAPTURE_IRQ_O            = cap_irq_reg;
    assign TIMEOUT_IRQ_O            = to_irq_reg;
endmodule

// ==== core/timer_cfg.svh ====
// Register offsets, field positions, reset values and timing counts of the timer block
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define TMR_ADDR        8'hf1
`define PRE_ADDR        8'hf2
`define START_ADDR      8'hf3
`define DCTL_ADDR       8'hd0
`define DEDGE_ADDR      8'hd1
`define DRLH_ADDR       8'hd2
`define DRLL_ADDR       8'hd3
`define DCAPH_ADDR      8'hd4
`define DCAPL_ADDR      8'hd5
`define TMR_SEL_HI      7
`define TMR_SEL_LO      6
`define TMR_EN_BIT      3
`define TMR_LOAD_BIT    2
`define SEL_OFF         2'b00
`define SEL_GENERAL     2'b10
`define PRE_VAL_HI      7
`define PRE_VAL_LO      2
`define PRE_CONT_BIT    0
`define DCTL_EN_BIT     7
`define DCTL_TO_BIT     5
`define DCTL_CLK_HI     4
`define DCTL_CLK_LO     3
`define DCTL_CAPIE_BIT  2
`define DCTL_TOIE_BIT   1
`define DEDGE_SEL_HI    5
`define DEDGE_SEL_LO    4
`define DEDGE_FALL_ST   1
`define DEDGE_RISE_ST   0
`define REG_RST         8'h00
`define GT_TICK_DIV     4
`endif

// ==== core/timer_pkg.sv ====
// Shared types of the timer block
package timer_pkg;
    typedef logic [7:0] reg_addr_t;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        DM_IDLE  = 2'b01,
        DM_COUNT = 2'b10
    } demod_state_t;
endpackage

// ==== core/timer_link_if.sv ====
// Signals between the timer control file and its two counting units
`timescale 1ns/1ps
interface timer_link_if;
    logic       gt_restart;
    logic       gt_phase_clr;
    logic       gt_enable;
    logic       gt_continuous;
    logic [5:0] gt_pre_value;
    logic [7:0] gt_start_value;
    logic       gt_eoc;
    logic       dm_enable;
    logic [1:0] dm_clk_sel;
    logic       dm_rise;
    logic       dm_fall;
    logic [7:0] dm_reload;
    logic       dm_cap_rise;
    logic       dm_cap_fall;
    logic [7:0] dm_cap_value;
    logic       dm_timeout;
    modport gt_ctrl (output gt_restart, gt_phase_clr, gt_enable, gt_continuous,
                     gt_pre_value, gt_start_value, input gt_eoc);
    modport gt_unit (input gt_restart, gt_phase_clr, gt_enable, gt_continuous,
                     gt_pre_value, gt_start_value, output gt_eoc);
    modport dm_ctrl (output dm_enable, dm_clk_sel, dm_rise, dm_fall, dm_reload,
                     input dm_cap_rise, dm_cap_fall, dm_cap_value, dm_timeout);
    modport dm_unit (input dm_enable, dm_clk_sel, dm_rise, dm_fall, dm_reload,
                     output dm_cap_rise, dm_cap_fall, dm_cap_value, dm_timeout);
endinterface

// ==== core/general_down_counter.sv ====
// Prescaler and 8-bit general down-counter with end-of-count pulse
`timescale 1ns/1ps
`include "timer_cfg.svh"
module general_down_counter
#(
    parameter int TICK_DIV = `GT_TICK_DIV
)
(
    input  wire logic     clk_i,
    input  wire logic     rst_n_i,
    timer_link_if.gt_unit lnk
);
    import timer_pkg::*;
    localparam int PW = (TICK_DIV < 2) ? 1 : $clog2(TICK_DIV);
    if (TICK_DIV < 2)
    begin : g_chk
        $error("TICK_DIV must be at least 2");
    end

    logic [PW-1:0] phase_reg, phase_next;
    logic [5:0]    pre_reg, pre_next;
    logic [7:0]    cnt_reg, cnt_next;
    logic          eoc_reg, eoc_next;

    always_comb
    begin
        phase_next = phase_reg;
        pre_next   = pre_reg;
        cnt_next   = cnt_reg;
        eoc_next   = 1'b0;
        if (lnk.gt_restart)
        begin
            // Retrigger: counting restarts from the start values
            phase_next = '0;
            pre_next   = lnk.gt_pre_value;
            cnt_next   = lnk.gt_start_value;
        end
        else if (lnk.gt_phase_clr)
        begin
            phase_next = '0;
        end
        else if (lnk.gt_enable)
        begin
            if (phase_reg == PW'(TICK_DIV - 1))
            begin
                phase_next = '0;
                // Value 0 wraps to 63 or 255, so it divides by 64 or 256
                if (pre_reg == 6'h01)
                begin
                    pre_next = lnk.gt_pre_value;
                    if (cnt_reg == 8'h01)
                    begin
                        eoc_next = 1'b1;
                        cnt_next = lnk.gt_start_value;
                    end
                    else
                    begin
                        cnt_next = cnt_reg - 8'h01;
                    end
                end
                else
                begin
                    pre_next = pre_reg - 6'h01;
                end
            end
            else
            begin
                phase_next = phase_reg + PW'(1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            phase_reg <= '0;
            pre_reg   <= 6'h00;
            cnt_reg   <= 8'h00;
            eoc_reg   <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            pre_reg   <= pre_next;
            cnt_reg   <= cnt_next;
            eoc_reg   <= eoc_next;
        end
    end

    assign lnk.gt_eoc = eoc_reg;
endmodule

// ==== core/demod_down_counter.sv ====
// Demodulation down-counter: edge start, capture, reload and time-out
`timescale 1ns/1ps
`include "timer_cfg.svh"
module demod_down_counter
(
    input  wire logic     clk_i,
    input  wire logic     rst_n_i,
    timer_link_if.dm_unit lnk
);
    import timer_pkg::*;

    demod_state_t state_reg, state_next;
    logic [7:0]   count_reg, count_next;
    logic [2:0]   div_reg, div_next;
    logic [7:0]   capv_reg, capv_next;
    logic         caprise_reg, caprise_next;
    logic         capfall_reg, capfall_next;
    logic         to_reg, to_next;
    logic [2:0]   mask;
    logic         tick;
    logic         edge_seen;

    always_comb
    begin
        mask         = (3'b001 << lnk.dm_clk_sel) - 3'b001;
        tick         = ((div_reg & mask) == 3'b000);
        edge_seen    = lnk.dm_rise | lnk.dm_fall;
        state_next   = state_reg;
        count_next   = count_reg;
        div_next     = div_reg + 3'b001;
        capv_next    = capv_reg;
        caprise_next = 1'b0;
        capfall_next = 1'b0;
        to_next      = 1'b0;
        if (!lnk.dm_enable)
        begin
            state_next = DM_IDLE;
            count_next = lnk.dm_reload;
            div_next   = 3'b000;
        end
        else
        begin
            unique case (state_reg)
                DM_IDLE:
                begin
                    if (edge_seen)
                    begin
                        state_next = DM_COUNT;
                        count_next = lnk.dm_reload;
                        div_next   = 3'b000;
                    end
                end
                DM_COUNT:
                begin
                    if (edge_seen)
                    begin
                        capv_next    = ~count_reg;
                        caprise_next = lnk.dm_rise;
                        capfall_next = lnk.dm_fall;
                        count_next   = lnk.dm_reload;
                        div_next     = 3'b000;
                    end
                    else if (tick)
                    begin
                        count_next = count_reg - 8'h01;
                        // Wraps to all ones on the following tick
                        to_next    = (count_reg == 8'h01);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg   <= DM_IDLE;
            count_reg   <= 8'h00;
            div_reg     <= 3'b000;
            capv_reg    <= 8'h00;
            caprise_reg <= 1'b0;
            capfall_reg <= 1'b0;
            to_reg      <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            count_reg   <= count_next;
            div_reg     <= div_next;
            capv_reg    <= capv_next;
            caprise_reg <= caprise_next;
            capfall_reg <= capfall_next;
            to_reg      <= to_next;
        end
    end

    assign lnk.dm_cap_rise  = caprise_reg;
    assign lnk.dm_cap_fall  = capfall_reg;
    assign lnk.dm_cap_value = capv_reg;
    assign lnk.dm_timeout   = to_reg;
endmodule

// ==== testbench/timer_toggle_assertions.sv ====
// Port-level assertions for the timer block
`timescale 1ns/1ps
module timer_toggle_assertions
(
    input wire logic                 CLK_SYS_I,
    input wire logic                 RST_N_I,
    input wire timer_pkg::reg_addr_t REG_ADDR_I,
    input wire logic                 REG_WR_I,
    input wire timer_pkg::byte_t     REG_WDATA_I,
    input wire logic                 PORT_DATA_BIT_I,
    input wire logic                 PORT_FIVE_DIR_BIT_I,
    input wire logic                 DEMOD_INPUT_I,
    input wire timer_pkg::byte_t     REG_RDATA_O,
    input wire logic                 TOGGLE_OUTPUT_PIN_O,
    input wire logic                 TOGGLE_OUTPUT_PIN_OE_N_O,
    input wire logic                 COUNTER_END_IRQ_O,
    input wire logic                 CAPTURE_IRQ_O,
    input wire logic                 TIMEOUT_IRQ_O
);
    import timer_pkg::*;
    logic [1:0] mode_q;
    logic [7:0] dctl_q;
    logic [4:0] quiet_q;
    logic       mode_wr;
    assign mode_wr = REG_WR_I && REG_ADDR_I == 8'hf1;
    // Shadow copies of the mode and demodulation control writes
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            mode_q  <= 2'h0;
            dctl_q  <= 8'h00;
            quiet_q <= 5'h1f;
        end
        else
        begin
            if (mode_wr)
                mode_q <= REG_WDATA_I[7:6];
            if (REG_WR_I && REG_ADDR_I == 8'hd0)
                dctl_q <= REG_WDATA_I;
            quiet_q <= $changed(DEMOD_INPUT_I) ? 5'h00 : quiet_q + {4'h0, quiet_q != 5'h1f};
        end
    end
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_N_I);
    load_clear_a: assert property (
        (mode_wr && REG_WDATA_I[2]) ##1 (REG_ADDR_I == 8'hf1 && !REG_WR_I) [*3]
        |-> REG_RDATA_O[2] == 1'b0) else $error("load bit stuck");
    load_force_a: assert property (
        mode_wr && REG_WDATA_I[7:6] == 2'b10 && REG_WDATA_I[2]
        |-> ##[1:2] TOGGLE_OUTPUT_PIN_O) else $error("load did not set pin");
    first_tick_a: assert property (
        mode_wr && REG_WDATA_I[3:2] == 2'b11 |-> ##3 !COUNTER_END_IRQ_O [*2])
        else $error("count ended too early after start");
    end_toggle_a: assert property (
        COUNTER_END_IRQ_O && mode_q == 2'b10 && $stable(mode_q) && !$past(mode_wr)
        |-> TOGGLE_OUTPUT_PIN_O != $past(TOGGLE_OUTPUT_PIN_O)) else $error("pin did not toggle");
    end_pulse_a: assert property (COUNTER_END_IRQ_O |=> !COUNTER_END_IRQ_O)
        else $error("end pulse too long");
    mode_off_a: assert property (
        mode_q == 2'b00 && $stable(mode_q) |-> TOGGLE_OUTPUT_PIN_O == $past(PORT_DATA_BIT_I))
        else $error("pin not following port data");
    pin_dir_a: assert property (
        TOGGLE_OUTPUT_PIN_OE_N_O == $past(PORT_FIVE_DIR_BIT_I)) else $error("pin enable wrong");
    cap_gate_a: assert property (
        CAPTURE_IRQ_O |-> dctl_q[2] && quiet_q < 5'h0c) else $error("capture irq without cause");
    timeout_gate_a: assert property (TIMEOUT_IRQ_O |-> dctl_q[1])
        else $error("timeout irq while masked");
endmodule
bind timer_toggle_top timer_toggle_assertions u_chk (.*);

// ==== testbench/demod_pulse_source.sv ====
// Far-side model: pulse source on the demodulation input, watcher of the toggle pin
`timescale 1ns/1ps
module demod_pulse_source
(
    input  wire logic clk_i,
    input  wire logic pin_i,
    input  wire logic pin_oe_n_i,
    output logic      pulse_o
);
    int   n_toggles;
    logic last_q;
    initial
    begin
        pulse_o = 1'b0;
        n_toggles = 0;
        last_q = 1'b0;
    end
    // A released pin carries no meaning, so only driven levels are counted
    always @(posedge clk_i)
    begin
        if (pin_oe_n_i === 1'b0 && pin_i !== last_q)
            n_toggles++;
        last_q <= pin_i;
    end
    // Rise, hold high h, fall, hold low l, rise again and stay high
    task automatic pulse(input int h, input int l);
        @(posedge clk_i);
        pulse_o <= 1'b1;
        repeat (h) @(posedge clk_i);
        pulse_o <= 1'b0;
        repeat (l) @(posedge clk_i);
        pulse_o <= 1'b1;
    endtask
endmodule

// ==== testbench/timer_toggle_top_tb_top.sv ====
// Register-level tests of the timer block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module timer_toggle_top_tb_top;
    import timer_pkg::*;
    logic      clk, rst_n, wr_en, pdat, pdir, pin, oe_n, eirq, cirq, tirq, din;
    reg_addr_t addr;
    byte_t     wdata, rdata, d;
    int        mismatches, n_checks, n_end, n_cap, n_to, cyc, c0, c1;
    logic      pa;
    timer_toggle_top DUT (.CLK_SYS_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr),
        .REG_WR_I(wr_en), .REG_WDATA_I(wdata), .PORT_DATA_BIT_I(pdat),
        .PORT_FIVE_DIR_BIT_I(pdir), .DEMOD_INPUT_I(din), .REG_RDATA_O(rdata),
        .TOGGLE_OUTPUT_PIN_O(pin), .TOGGLE_OUTPUT_PIN_OE_N_O(oe_n),
        .COUNTER_END_IRQ_O(eirq), .CAPTURE_IRQ_O(cirq), .TIMEOUT_IRQ_O(tirq));
    demod_pulse_source u_src (.clk_i(clk), .pin_i(pin), .pin_oe_n_i(oe_n), .pulse_o(din));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (eirq === 1'b1) n_end++;
        if (cirq === 1'b1) n_cap++;
        if (tirq === 1'b1) n_to++;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input reg_addr_t a, input byte_t v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input reg_addr_t a, output byte_t v);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        #1 v = rdata;
    endtask
    // Waits for the end-of-count pulse, bounded so a dead counter cannot hang
    task automatic wait_end(output int c);
        int k;
        k = 0;
        do
        begin
            @(posedge clk);
            #1 k++;
        end
        while (eirq !== 1'b1 && k < 3000);
        `CHK(k < 3000, 1'b1)
        c = cyc;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    initial
    begin
        {rst_n, wr_en, pdat, pdir, addr, wdata} = {1'b0, 1'b0, 1'b0, 1'b1, 16'h0000};
        {mismatches, n_checks, n_end, n_cap, n_to, cyc} = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'hf1, d); `CHK(d, 8'h00)
        rd(8'h10, d); `CHK(d, 8'h00)
        @(posedge clk);
        pdir <= 1'b0;
        wr(8'hf2, 8'h09);
        wr(8'hf3, 8'h03);
        wr(8'hf1, 8'h8c);
        rd(8'hf1, d); `CHK(d, 8'h88)
        wait_end(c0);
        pa = pin;
        wait_end(c1);
        `CHK(c1 - c0, 24)
        `CHK(pin, ~pa)
        wait_end(c0);
        `CHK(cyc - c1, 24)
        `CHK(u_src.n_toggles > 2, 1'b1)
        wr(8'hf1, 8'h80);
        c0 = n_end;
        repeat (80) @(posedge clk);
        `CHK(n_end, c0)
        wr(8'hf1, 8'h8c);
        repeat (10) @(posedge clk);
        wr(8'hf1, 8'h8c);
        c0 = cyc;
        wait_end(c1);
        `CHK(c1 - c0 >= 22 && c1 - c0 <= 32, 1'b1)
        wr(8'hf1, 8'h80);
        wr(8'hf2, 8'h08);
        wr(8'hf1, 8'h8c);
        c0 = n_end;
        repeat (100) @(posedge clk);
        `CHK(n_end - c0, 1)
        rd(8'hf1, d); `CHK(d[3], 1'b0)
        wr(8'hf1, 8'h00);
        pdat <= 1'b1;
        repeat (2) @(posedge clk);
        #1 `CHK(pin, 1'b1)
        wr(8'hd4, 8'h55);
        rd(8'hd4, d); `CHK(d, 8'h00)
        wr(8'hd2, 8'hff);
        wr(8'hd3, 8'hff);
        wr(8'hd1, 8'h30);
        wr(8'hd0, 8'h86);
        u_src.pulse(20, 30);
        repeat (12) @(posedge clk);
        rd(8'hd4, d); `CHK(d >= 8'h11 && d <= 8'h17, 1'b1)
        rd(8'hd5, d); `CHK(d >= 8'h1b && d <= 8'h21, 1'b1)
        rd(8'hd1, d); `CHK(d[1:0], 2'b11)
        `CHK(n_cap, 2)
        repeat (300) @(posedge clk);
        `CHK(n_to > 0, 1'b1)
        rd(8'hd0, d); `CHK(d[5], 1'b1)
        `CHK(n_cap, 2)
        give_verdict();
    end
endmodule
